// File: design/gdsg_consts.svh
// constants for the gate drive supply guard: offsets, fields, resets, timing
`ifndef GDSG_CONSTS_SVH
`define GDSG_CONSTS_SVH

// register offsets (byte addresses, one word each)
`define GDSG_SUPPLY_CFG_OFS 8'h00
`define GDSG_PUMP_CFG_OFS 8'h04
`define GDSG_STATUS_OFS 8'h08
`define GDSG_CTRL_OFS 8'h0C

// supply configuration fields
`define GDSG_VSEL_LSB 0
`define GDSG_PRECHG_BIT 2
// pump configuration fields
`define GDSG_CLKSEL_LSB 0
`define GDSG_SPREAD_BIT 2
// status fields
`define GDSG_ST_LS_UV_BIT 0
`define GDSG_ST_HS_UV_BIT 1
`define GDSG_ST_LS_FLT_BIT 2
`define GDSG_ST_HS_FLT_BIT 3
`define GDSG_ST_PRECHG_DONE_BIT 4
`define GDSG_ST_PRECHG_ACT_BIT 5
// control fields (write one to clear faults)
`define GDSG_CTRL_CLR_LS_BIT 0
`define GDSG_CTRL_CLR_HS_BIT 1

// reset values
`define GDSG_SUPPLY_CFG_RST 3'h0
`define GDSG_PUMP_CFG_RST 3'h0

// drive voltage codes
`define GDSG_V7 2'h3
`define GDSG_V10 2'h2
`define GDSG_V12 2'h0
`define GDSG_V15 2'h1

// pump clock divider half periods for the four selections
`define GDSG_DIV0 8'h32
`define GDSG_DIV1 8'h28
`define GDSG_DIV2 8'h19
`define GDSG_DIV3 8'h0A
// spread spectrum swing in divider steps and step dwell
`define GDSG_SPREAD_SPAN 4'h8
`define GDSG_SPREAD_DWELL 8'h10

`endif

// File: design/gdsg_pkg.sv
// types for the gate drive supply guard
package gdsg_pkg;
	typedef enum logic [1:0] {GDSG_PC_IDLE, GDSG_PC_RUN, GDSG_PC_DONE} gdsg_pc_e;
	typedef logic [1:0] gdsg_vsel_t;
	typedef logic [1:0] gdsg_clksel_t;
endpackage : gdsg_pkg

// File: design/gdsg_pump_clk.sv
// charge pump clock generator with selectable rate and spread spectrum
`timescale 1ns/100ps
`include "gdsg_consts.svh"
module gdsg_pump_clk (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// configuration
	input wire gdsg_pkg::gdsg_clksel_t clk_select,
	input wire logic spread_enable,
	// pump clock out
	output logic pump_clk
);
	import gdsg_pkg::*;
	logic [7:0] cnt;
	logic [7:0] dwell;
	logic [3:0] offs;
	logic up;
	logic [7:0] next_cnt;
	logic [7:0] next_dwell;
	logic [3:0] next_offs;
	logic next_up;
	logic next_pump_clk;
	logic [7:0] base;
	logic [7:0] half;

	always_comb
	begin
		case (clk_select)
			2'h0: base = `GDSG_DIV0;
			2'h1: base = `GDSG_DIV1;
			2'h2: base = `GDSG_DIV2;
			default: base = `GDSG_DIV3;
		endcase
		// triangle sweep above nominal; off leaves base untouched
		half = spread_enable ? 8'(base + {4'h0, offs}) : base;
		next_cnt = cnt + 8'h01;
		next_pump_clk = pump_clk;
		if (cnt >= half - 8'h01)
		begin
			next_cnt = 8'h00;
			next_pump_clk = ~pump_clk;
		end
		next_dwell = dwell + 8'h01;
		next_offs = offs;
		next_up = up;
		if (!spread_enable)
		begin
			next_dwell = 8'h00;
			next_offs = 4'h0;
			next_up = 1'b1;
		end
		else if (dwell == `GDSG_SPREAD_DWELL)
		begin
			next_dwell = 8'h00;
			if (up && offs == `GDSG_SPREAD_SPAN)
				next_up = 1'b0;
			else if (!up && offs == 4'h0)
				next_up = 1'b1;
			else
				next_offs = up ? offs + 4'h1 : offs - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 8'h00;
			dwell <= 8'h00;
			offs <= 4'h0;
			up <= 1'b1;
			pump_clk <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			dwell <= next_dwell;
			offs <= next_offs;
			up <= next_up;
			pump_clk <= next_pump_clk;
		end
	end
endmodule : gdsg_pump_clk

// File: design/gdsg_sync.sv
// two-flop synchroniser for one rail comparator level
`timescale 1ns/100ps
module gdsg_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// level in and out
	input wire logic din,
	output logic dout
);
	logic meta;
	logic next_meta;
	logic next_dout;

	always_comb
	begin
		next_meta = din;
		next_dout = meta;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			meta <= next_meta;
			dout <= next_dout;
		end
	end
endmodule : gdsg_sync

// File: design/gdsg_top.sv
// gate drive supply guard: setpoint, pump clock, pre-charge, lockout, pull-down
`timescale 1ns/100ps
`include "gdsg_consts.svh"
module gdsg_top #(
	parameter int NUM_GATES = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// driver enable from the controller
	input wire logic driver_enable_pin,
	// rail comparators, high means above threshold (hysteresis in analog)
	input wire logic ls_rail_ok,
	input wire logic hs_rail_ok,
	// buck output good for pre-charge
	input wire logic buck_output_rail_ok,
	// pwm in and gate drive out
	input wire logic [NUM_GATES-1:0] pwm_in,
	output logic [NUM_GATES-1:0] gate_drive,
	output logic gate_hiz,
	// gate to source rise detectors and pull-down controls
	input wire logic [NUM_GATES-1:0] gate_rise,
	output logic [NUM_GATES-1:0] weak_pulldown_on,
	output logic [NUM_GATES-1:0] strong_pulldown_on,
	// pump controls
	output gdsg_pkg::gdsg_vsel_t gate_drive_voltage,
	output logic pump_clk,
	output logic pump_run,
	output logic precharge_active,
	// fault pin: output enable low drives it low (open drain)
	output logic fault_out_n_o,
	output logic fault_out_n_oe
);
	import gdsg_pkg::*;

	logic [2:0] supply_cfg;
	logic [2:0] pump_config_reg;
	logic ls_fault;
	logic hs_fault;
	logic [31:0] rdata_q;
	logic [2:0] next_supply_cfg;
	logic [2:0] next_pump_config_reg;
	logic next_ls_fault;
	logic next_hs_fault;
	logic [31:0] next_rdata;
	logic ls_ok_s;
	logic hs_ok_s;
	logic ls_ok_d;
	logic hs_ok_d;
	gdsg_pc_e pc_state;
	gdsg_pc_e next_pc_state;
	logic pump_precharge_enable;
	logic drive_on;
	logic [31:0] status_word;

	assign pump_precharge_enable = supply_cfg[`GDSG_PRECHG_BIT];

	// comparator levels are asynchronous to clk
	gdsg_sync u_ls_sync (
		.clk(clk),
		.rstn(rstn),
		.din(ls_rail_ok),
		.dout(ls_ok_s)
	);
	gdsg_sync u_hs_sync (
		.clk(clk),
		.rstn(rstn),
		.din(hs_rail_ok),
		.dout(hs_ok_s)
	);

	gdsg_pump_clk u_pump_clk (
		.clk(clk),
		.rstn(rstn),
		.clk_select(pump_config_reg[`GDSG_CLKSEL_LSB +: 2]),
		.spread_enable(pump_config_reg[`GDSG_SPREAD_BIT]),
		.pump_clk(pump_clk)
	);

	// one setpoint for both pumps
	assign gate_drive_voltage = supply_cfg[`GDSG_VSEL_LSB +: 2];

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[`GDSG_ST_LS_UV_BIT] = ~ls_ok_s;
		status_word[`GDSG_ST_HS_UV_BIT] = ~hs_ok_s;
		status_word[`GDSG_ST_LS_FLT_BIT] = ls_fault;
		status_word[`GDSG_ST_HS_FLT_BIT] = hs_fault;
		status_word[`GDSG_ST_PRECHG_DONE_BIT] = (pc_state == GDSG_PC_DONE);
		status_word[`GDSG_ST_PRECHG_ACT_BIT] = precharge_active;
	end

	// register file and fault flags
	always_comb
	begin
		next_supply_cfg = supply_cfg;
		next_pump_config_reg = pump_config_reg;
		next_ls_fault = ls_fault;
		next_hs_fault = hs_fault;
		next_rdata = 32'h0000_0000;
		if (reg_wr)
		begin
			case (reg_addr)
				`GDSG_SUPPLY_CFG_OFS: next_supply_cfg = reg_wdata[2:0];
				`GDSG_PUMP_CFG_OFS: next_pump_config_reg = reg_wdata[2:0];
				`GDSG_CTRL_OFS:
				begin
					if (reg_wdata[`GDSG_CTRL_CLR_LS_BIT])
						next_ls_fault = 1'b0;
					if (reg_wdata[`GDSG_CTRL_CLR_HS_BIT])
						next_hs_fault = 1'b0;
				end
				default: ;
			endcase
		end
		// falling edge of a rail that was good; set wins over a clear
		if (ls_ok_d && !ls_ok_s)
			next_ls_fault = 1'b1;
		if (hs_ok_d && !hs_ok_s)
			next_hs_fault = 1'b1;
		if (reg_rd)
		begin
			case (reg_addr)
				`GDSG_SUPPLY_CFG_OFS: next_rdata = {29'h0, supply_cfg};
				`GDSG_PUMP_CFG_OFS: next_rdata = {29'h0, pump_config_reg};
				`GDSG_STATUS_OFS: next_rdata = status_word;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			supply_cfg <= `GDSG_SUPPLY_CFG_RST;
			pump_config_reg <= `GDSG_PUMP_CFG_RST;
			ls_fault <= 1'b0;
			hs_fault <= 1'b0;
			rdata_q <= 32'h0000_0000;
			ls_ok_d <= 1'b0;
			hs_ok_d <= 1'b0;
		end
		else
		begin
			supply_cfg <= next_supply_cfg;
			pump_config_reg <= next_pump_config_reg;
			ls_fault <= next_ls_fault;
			hs_fault <= next_hs_fault;
			rdata_q <= next_rdata;
			ls_ok_d <= ls_ok_s;
			hs_ok_d <= hs_ok_s;
		end
	end

	assign reg_rdata = rdata_q;

	// pre-charge sequencer: only once after power-up reset
	always_comb
	begin
		next_pc_state = pc_state;
		case (pc_state)
			GDSG_PC_IDLE:
				if (driver_enable_pin)
					next_pc_state = GDSG_PC_DONE;
				else if (pump_precharge_enable)
					next_pc_state = GDSG_PC_RUN;
			GDSG_PC_RUN:
				// stop at buck level, when the driver is enabled or when the pre-charge enable bit is cleared
				if (driver_enable_pin || buck_output_rail_ok || !pump_precharge_enable)
					next_pc_state = GDSG_PC_DONE;
			GDSG_PC_DONE:
				next_pc_state = GDSG_PC_DONE;
			default:
				next_pc_state = GDSG_PC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc_state <= GDSG_PC_IDLE;
		end
		else
		begin
			pc_state <= next_pc_state;
		end
	end

	assign precharge_active = (pc_state == GDSG_PC_RUN);
	assign pump_run = driver_enable_pin | precharge_active;

	// lockout gating is combinational on synchronised status
	assign drive_on = driver_enable_pin & ls_ok_s & hs_ok_s;
	assign gate_hiz = ~drive_on;
	assign gate_drive = drive_on ? pwm_in : '0;
	assign weak_pulldown_on = '1;
	assign strong_pulldown_on = driver_enable_pin ? '0 : gate_rise;

	// open drain: pin driven low while any fault stands
	assign fault_out_n_o = 1'b0;
	assign fault_out_n_oe = ~(ls_fault | hs_fault);

	sequence s_ls_drop;
		ls_ok_d && !ls_ok_s;
	endsequence
	sequence s_hs_drop;
		hs_ok_d && !hs_ok_s;
	endsequence

	property p_vsel;
		@(posedge clk) disable iff (!rstn)
		reg_wr && reg_addr == `GDSG_SUPPLY_CFG_OFS |=> gate_drive_voltage == $past(reg_wdata[1:0]);
	endproperty
	a_vsel: assert property (p_vsel) else $error("setpoint not applied");

	property p_ls_block;
		@(posedge clk) disable iff (!rstn)
		!ls_ok_s |-> gate_drive == '0 && gate_hiz;
	endproperty
	a_ls_block: assert property (p_ls_block) else $error("pwm passed during low rail lockout");

	property p_release;
		@(posedge clk) disable iff (!rstn)
		ls_ok_s && hs_ok_s && driver_enable_pin |-> gate_drive == pwm_in && !gate_hiz;
	endproperty
	a_release: assert property (p_release) else $error("pwm blocked with rails good");

	property p_ls_fault;
		@(posedge clk) disable iff (!rstn)
		s_ls_drop |=> ls_fault && !fault_out_n_oe;
	endproperty
	a_ls_fault: assert property (p_ls_fault) else $error("low rail drop not reported");

	property p_hs_fault;
		@(posedge clk) disable iff (!rstn)
		s_hs_drop |=> hs_fault && !fault_out_n_oe;
	endproperty
	a_hs_fault: assert property (p_hs_fault) else $error("high rail drop not reported");

	property p_fault_pin;
		@(posedge clk) disable iff (!rstn)
		(ls_fault || hs_fault) |-> !fault_out_n_oe && !fault_out_n_o;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");

	property p_once;
		@(posedge clk) disable iff (!rstn)
		pc_state == GDSG_PC_DONE |=> pc_state == GDSG_PC_DONE;
	endproperty
	a_once: assert property (p_once) else $error("pre-charge re-armed");

	property p_no_pc;
		@(posedge clk) disable iff (!rstn)
		!pump_precharge_enable && pc_state == GDSG_PC_IDLE |=> !precharge_active;
	endproperty
	a_no_pc: assert property (p_no_pc) else $error("pre-charge without enable");

	property p_weak;
		@(posedge clk) disable iff (!rstn)
		weak_pulldown_on == '1;
	endproperty
	a_weak: assert property (p_weak) else $error("weak pull-down dropped");

	property p_strong;
		@(posedge clk) disable iff (!rstn)
		!driver_enable_pin |-> strong_pulldown_on == gate_rise;
	endproperty
	a_strong: assert property (p_strong) else $error("strong pull-down missing");

	property p_sync;
		@(posedge clk) disable iff (!rstn)
		$fell(ls_rail_ok) ##1 !ls_rail_ok |=> !ls_ok_s;
	endproperty
	a_sync: assert property (p_sync) else $error("comparator sync latency wrong");

	property p_hs_block;
		@(posedge clk) disable iff (!rstn)
		!hs_ok_s |-> gate_drive == '0 && gate_hiz;
	endproperty
	a_hs_block: assert property (p_hs_block) else $error("pwm passed during high rail lockout");

	property p_pc_stop;
		@(posedge clk) disable iff (!rstn)
		precharge_active && driver_enable_pin |=> !precharge_active;
	endproperty
	a_pc_stop: assert property (p_pc_stop) else $error("pre-charge ran past driver enable");
endmodule : gdsg_top

// File: test/gdsg_mcu_model.sv
// controller side model: open-drain fault line with its pull-up
`timescale 1ns/100ps
module gdsg_mcu_model (
	// fault pin as driven by the guard
	input wire logic fault_out_n_o,
	input wire logic fault_out_n_oe,
	// level the controller sees
	output logic fault_out_n
);
	// pull-up wins whenever the guard releases the line
	assign fault_out_n = fault_out_n_oe ? 1'b1 : fault_out_n_o;
endmodule : gdsg_mcu_model

// File: test/gdsg_top_bench.sv
// self-checking bench for the gate drive supply guard
`timescale 1ns/100ps
`include "gdsg_consts.svh"
module gdsg_top_bench;
	import gdsg_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic driver_enable_pin = 1'b0;
	logic ls_rail_ok = 1'b1;
	logic hs_rail_ok = 1'b1;
	logic buck_output_rail_ok = 1'b0;
	logic [5:0] pwm_in = 6'h00;
	logic [5:0] gate_drive;
	logic gate_hiz;
	logic [5:0] gate_rise = 6'h00;
	logic [5:0] weak_pulldown_on;
	logic [5:0] strong_pulldown_on;
	gdsg_vsel_t gate_drive_voltage;
	logic pump_clk;
	logic pump_run;
	logic precharge_active;
	logic fault_out_n_o;
	logic fault_out_n_oe;
	logic fault_out_n;
	logic rd_d = 1'b0;
	logic pclk_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [1:0] codes[4] = '{`GDSG_V7, `GDSG_V10, `GDSG_V12, `GDSG_V15};
	int fails = 0;
	int n_compared = 0;
	int toggles = 0;
	int cnt[5];

	gdsg_top #(.NUM_GATES(6)) gdsg_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .driver_enable_pin(driver_enable_pin),
		.ls_rail_ok(ls_rail_ok), .hs_rail_ok(hs_rail_ok), .buck_output_rail_ok(buck_output_rail_ok),
		.pwm_in(pwm_in), .gate_drive(gate_drive), .gate_hiz(gate_hiz), .gate_rise(gate_rise),
		.weak_pulldown_on(weak_pulldown_on), .strong_pulldown_on(strong_pulldown_on),
		.gate_drive_voltage(gate_drive_voltage), .pump_clk(pump_clk), .pump_run(pump_run),
		.precharge_active(precharge_active), .fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe));
	gdsg_mcu_model gdsg_mcu_model_inst (.fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe),
		.fault_out_n(fault_out_n));

	always #5 clk = ~clk;

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= addr;
		exp_q.push_back(exp);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// read data stands only in the cycle after the strobe
	always @(posedge clk)
	begin
		rd_d <= reg_rd;
		pclk_d <= pump_clk;
		if (pump_clk !== pclk_d)
			toggles++;
	end
	always @(negedge clk)
		if (rd_d && exp_q.size() > 0)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);

	initial
	begin
		#100000;
		fails++;
		finish_test();
	end

	initial
	begin
		void'($urandom(32'he266));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd(`GDSG_SUPPLY_CFG_OFS, 32'h0000_0000);
		rd(`GDSG_STATUS_OFS, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		// one-shot pre-charge before the first enable
		wr(`GDSG_SUPPLY_CFG_OFS, 32'h0000_0004);
		repeat (2) @(negedge clk);
		chk("precharge_active", 1'h1, precharge_active);
		chk("pump_run", 1'h1, pump_run);
		@(posedge clk) driver_enable_pin <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("precharge_active", 1'h0, precharge_active);
		@(posedge clk) driver_enable_pin <= 1'b0;
		repeat (5) @(negedge clk);
		chk("precharge_active", 1'h0, precharge_active);
		rd(`GDSG_STATUS_OFS, 32'h0000_0010);
		buck_output_rail_ok <= 1'b1;
		// every setpoint code lands on the shared pump setpoint
		for (int i = 0; i < 4; i++)
		begin
			wr(`GDSG_SUPPLY_CFG_OFS, 32'(codes[i]));
			@(negedge clk);
			chk("gate_drive_voltage", 32'(codes[i]), 32'(gate_drive_voltage));
			rd(`GDSG_SUPPLY_CFG_OFS, 32'(codes[i]));
		end
		// pump clock rates, then spread on the fastest
		for (int s = 0; s < 5; s++)
		begin
			wr(`GDSG_PUMP_CFG_OFS, (s == 4) ? 32'h0000_0007 : 32'(s));
			toggles = 0;
			repeat (300) @(posedge clk);
			cnt[s] = toggles;
			chk("pump_clk_toggles", 1'h1, 32'(toggles >= 2));
		end
		chk("pump_rate_order", 1'h1, 32'(cnt[3] > cnt[0]));
		// sweep only stretches the half period, so spread runs slower on average
		chk("pump_spread_slower", 1'h1, 32'(cnt[4] < cnt[3]));
		// lockout of each rail in turn
		@(posedge clk) driver_enable_pin <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			@(posedge clk) pwm_in <= 6'($urandom);
			@(negedge clk);
			chk("gate_drive", 32'(pwm_in), 32'(gate_drive));
			chk("gate_hiz", 1'h0, gate_hiz);
			@(posedge clk);
			if (r == 0)
				ls_rail_ok <= 1'b0;
			else
				hs_rail_ok <= 1'b0;
			repeat (4) @(negedge clk);
			chk("gate_hiz", 1'h1, gate_hiz);
			chk("gate_drive", 32'h0000_0000, 32'(gate_drive));
			chk("fault_out_n", 1'h0, fault_out_n);
			rd(`GDSG_STATUS_OFS, 32'h0000_0010 | (32'h0000_0005 << r));
			ls_rail_ok <= 1'b1;
			hs_rail_ok <= 1'b1;
			repeat (4) @(negedge clk);
			chk("gate_hiz", 1'h0, gate_hiz);
			chk("fault_out_n", 1'h0, fault_out_n);
			wr(`GDSG_CTRL_OFS, 32'(1 << r));
			repeat (2) @(negedge clk);
			chk("fault_out_n", 1'h1, fault_out_n);
		end
		// pull-downs while the driver is off and on
		@(posedge clk)
		begin
			driver_enable_pin <= 1'b0;
			gate_rise <= 6'($urandom);
		end
		@(negedge clk);
		chk("strong_pulldown_on", 32'(gate_rise), 32'(strong_pulldown_on));
		chk("weak_pulldown_on", 32'h0000_003F, 32'(weak_pulldown_on));
		@(posedge clk) driver_enable_pin <= 1'b1;
		@(negedge clk);
		chk("strong_pulldown_on", 32'h0000_0000, 32'(strong_pulldown_on));
		chk("weak_pulldown_on", 32'h0000_003F, 32'(weak_pulldown_on));
		repeat (3) @(posedge clk);
		finish_test();
	end
endmodule : gdsg_top_bench
